/* File: format_pkg.sv */
// Constants, field positions and mode encoding for the tape frame formatter.
// Assumes a single 25 MHz clock and a timing unit that delivers the slow rates as pin levels.
// Operation
// - Power-on command enters record mode unless end-of-tape-recording is present.
// - Recorder step clock runs at 15 Hz in record, held high otherwise.
// - End-of-tape-recording enters standby; data continues, stepping stops.
// - Standby exits only on playback request; power-off still acts.
// - Playback accepted only with downlink ground present and no end-of-tape-playback.
// - Entering playback powers the three oscillators and the mixer amplifier.
// - Playback motor enable idles high, low in playback.
// - Playback start goes low 16/15 s after motor enable, high at end.
// - End-of-tape-playback, power-on or downlink loss ends playback into record.
// - Only the selected timing unit's inputs are used; standby unit grounds.
// - Time code shifts in on its own clock; rest marks full burst.
// - Proton data captured on frame timing gate, sent unchanged to track 1.
// - Radiometer gets 15 Hz shift clock and 1/15 s word strobe every 8/15 s.
// - Radiometer start pulse lasts all of frame word 6.
// - Track 2 is a 7.5 Hz square wave from the frame timing gate.
// - Track 3 frame is 60 words of 7 bits, each after a 0 marker.
// - Words 1 and 2 are sixteen 1 bits without markers.
// - Words 3 to 6 carry 24-bit time code, last 4 bits unused.
// - Words 7 to 21 gate radiometer data, marker forced one bit in eight.
// - Words 22 to 60 carry 39 converted telemetry channels.
// - Power-on pulse resets converter logic and is forwarded to the recorder.
package format_pkg;
  localparam int unsigned      CLK_HZ          = 25_000_000;
  localparam int unsigned      START_DELAY_NUM = 16;
  localparam int unsigned      START_DELAY_DEN = 15;
  localparam longint unsigned  START_DELAY_L   = (longint'(CLK_HZ) * START_DELAY_NUM + START_DELAY_DEN - 1)
                                                 / START_DELAY_DEN;
  localparam int unsigned      START_DELAY_CYCLES = int'(START_DELAY_L);
  localparam int unsigned      WORD_W          = 6;
  localparam int unsigned      BIT_W           = 3;
  localparam int unsigned      TC_W            = 24;
  localparam int unsigned      CNT_W           = 32;
  localparam logic [5:0]       LAST_WORD       = 6'h3b;
  localparam logic [2:0]       LAST_BIT        = 3'h7;
  localparam logic [2:0]       MARKER_SLOT     = 3'h0;
  localparam logic [5:0]       DATA_BITS       = 6'h07;
  localparam logic [5:0]       FRAME_MARK_END  = 6'h01;
  localparam logic [5:0]       TC_FIRST_WORD   = 6'h02;
  localparam logic [5:0]       TC_LAST_WORD    = 6'h05;
  localparam logic [5:0]       TC_BITS         = 6'h18;
  localparam logic [5:0]       RAD_START_WORD  = 6'h05;
  localparam logic [5:0]       RAD_FIRST_WORD  = 6'h06;
  localparam logic [5:0]       RAD_LAST_WORD   = 6'h14;
  localparam logic [5:0]       TLM_FIRST_WORD  = 6'h15;
  typedef enum logic [1:0] {MODE_OFF, MODE_RECORD, MODE_STANDBY, MODE_PLAYBACK} mode_t;
endpackage

/* File: timecode_if.sv */
// Interface between the frame builder and the time code capture.
// Assumes all members are already synchronous to clk.
`timescale 1ns/1ns
interface timecode_if;
  logic                  shift_clk;
  logic                  shift_data;
  logic                  rest;
  logic [23:0]           word;
  modport capture (input shift_clk, input shift_data, input rest, output word);
  modport user    (output shift_clk, output shift_data, output rest, input word);
endinterface

/* File: pin_sync.sv */
// Three-stage synchroniser for a bundle of pin levels.
// Assumes inputs are asynchronous to clk; output changes once stages two and three agree.
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] pins,
  output logic      [W-1:0] levels
);
  if (W < 1) $error("pin_sync width must be at least one");

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;
  logic [W-1:0] out_nxt;

  always_comb begin
    out_nxt = out_r;
    for (int i = 0; i < int'(W); i++) begin
      if (s2_r[i] == s3_r[i]) begin
        out_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      out_r <= '0;
    end else begin
      s1_r  <= pins;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign levels = out_r;
endmodule

/* File: timecode_capture.sv */
// Time code shift register, latched at the end of each burst.
// Assumes shift clock, data and rest arrive synchronised to clk.
`timescale 1ns/1ns
module timecode_capture (
  input  wire logic       clk,
  input  wire logic       reset,
  timecode_if.capture     tc
);
  logic [23:0] shift_r;
  logic [23:0] shift_nxt;
  logic [23:0] held_r;
  logic [23:0] held_nxt;
  logic        clk_d_r;
  logic        rest_d_r;

  always_comb begin
    shift_nxt = shift_r;
    held_nxt  = held_r;
    if (tc.shift_clk && !clk_d_r) begin
      shift_nxt = {tc.shift_data, shift_r[23:1]};
    end
    if (tc.rest && !rest_d_r) begin
      held_nxt = shift_r;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_r  <= 24'h000000;
      held_r   <= 24'h000000;
      clk_d_r  <= 1'b0;
      rest_d_r <= 1'b0;
    end else begin
      shift_r  <= shift_nxt;
      held_r   <= held_nxt;
      clk_d_r  <= tc.shift_clk;
      rest_d_r <= tc.rest;
    end
  end

  assign tc.word = held_r;
endmodule

/* File: tape_frame_formatter_mode_control.sv */
// Mode sequencer and track 3 frame builder for a three-track incremental recorder.
// Assumes timing unit rates, commands and recorder status arrive as asynchronous pin levels.
`timescale 1ns/1ns
module tape_frame_formatter_mode_control #(
  parameter int unsigned START_DELAY_CYCLES = format_pkg::START_DELAY_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic tick_9k6_a,
  input  wire logic tick_9k6_b,
  input  wire logic tick_15hz_a,
  input  wire logic tick_15hz_b,
  input  wire logic tc_clk_a,
  input  wire logic tc_clk_b,
  input  wire logic tc_data_a,
  input  wire logic tc_data_b,
  input  wire logic tc_rest_a,
  input  wire logic tc_rest_b,
  input  wire logic unit_a_standby_n,
  input  wire logic unit_b_standby_n,
  input  wire logic power_on_cmd,
  input  wire logic power_off_cmd,
  input  wire logic playback_cmd,
  input  wire logic eot_record_n,
  input  wire logic eot_playback_n,
  input  wire logic downlink_ground_n,
  input  wire logic proton_monitor_data,
  input  wire logic plate_radiometer_data,
  input  wire logic converter_serial_out,
  output logic      recorder_step_clk,
  output logic      recorder_reset,
  output logic      converter_power_on,
  output logic      recorder_power_on,
  output logic      oscillator_power_on,
  output logic      playback_motor_n,
  output logic      playback_start_n,
  output logic      track1_data,
  output logic      track2_data,
  output logic      track3_data,
  output logic      radiometer_shift_clk,
  output logic      radiometer_word_strobe,
  output logic      radiometer_start
);
  if (START_DELAY_CYCLES < 1) $error("start delay must be at least one cycle");
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Synchronised pin levels
  logic [20:0] sync_levels;
  logic        s_9k6_a;
  logic        s_9k6_b;
  logic        s_15_a;
  logic        s_15_b;
  logic        s_tcc_a;
  logic        s_tcc_b;
  logic        s_tcd_a;
  logic        s_tcd_b;
  logic        s_tcr_a;
  logic        s_tcr_b;
  logic        s_a_sb_n;
  logic        s_b_sb_n;
  logic        s_pon;
  logic        s_poff;
  logic        s_pb;
  logic        s_eotr_n;
  logic        s_eotp_n;
  logic        s_dl_n;
  logic        s_proton;
  logic        s_rad;
  logic        s_conv;

  pin_sync #(.W(21)) u_sync (
    .clk    (clk),
    .reset  (reset),
    .pins   ({tick_9k6_a, tick_9k6_b, tick_15hz_a, tick_15hz_b, tc_clk_a, tc_clk_b,
              tc_data_a, tc_data_b, tc_rest_a, tc_rest_b, unit_a_standby_n, unit_b_standby_n,
              power_on_cmd, power_off_cmd, playback_cmd, eot_record_n, eot_playback_n,
              downlink_ground_n, proton_monitor_data, plate_radiometer_data, converter_serial_out}),
    .levels (sync_levels)
  );

  assign {s_9k6_a, s_9k6_b, s_15_a, s_15_b, s_tcc_a, s_tcc_b, s_tcd_a, s_tcd_b, s_tcr_a, s_tcr_b,
          s_a_sb_n, s_b_sb_n, s_pon, s_poff, s_pb, s_eotr_n, s_eotp_n, s_dl_n, s_proton, s_rad,
          s_conv} = sync_levels;

  logic use_b;
  logic tick_9k6;
  logic tick_15;
  assign use_b    = !s_a_sb_n && s_b_sb_n;
  assign tick_9k6 = use_b ? s_9k6_b : s_9k6_a;
  assign tick_15  = use_b ? s_15_b : s_15_a;

  timecode_if tc_bus ();
  assign tc_bus.shift_clk  = use_b ? s_tcc_b : s_tcc_a;
  assign tc_bus.shift_data = use_b ? s_tcd_b : s_tcd_a;
  assign tc_bus.rest       = use_b ? s_tcr_b : s_tcr_a;

  timecode_capture u_tc (
    .clk   (clk),
    .reset (reset),
    .tc    (tc_bus.capture)
  );

  // Status levels, ground active
  logic eot_record;
  logic eot_playback;
  logic downlink_present;
  assign eot_record       = !s_eotr_n;
  assign eot_playback     = !s_eotp_n;
  assign downlink_present = !s_dl_n;

  // Edge detection and pending command events
  logic tick_9k6_d_r;
  logic tick_15_d_r;
  logic pon_d_r;
  logic poff_d_r;
  logic pb_d_r;
  logic pon_pend_r;
  logic poff_pend_r;
  logic pb_pend_r;
  logic pon_pend_nxt;
  logic poff_pend_nxt;
  logic pb_pend_nxt;
  logic stb_9k6;
  logic frame_timing_gate;
  logic pon_edge;
  logic pb_ok;
  assign stb_9k6           = tick_9k6 && !tick_9k6_d_r;
  assign frame_timing_gate = tick_15 && !tick_15_d_r;
  assign pon_edge          = s_pon && !pon_d_r;
  assign pb_ok             = downlink_present && !eot_playback;

  // events held until 9.6 kHz sample
  always_comb begin
    pon_pend_nxt  = pon_pend_r;
    poff_pend_nxt = poff_pend_r;
    pb_pend_nxt   = pb_pend_r;
    if (stb_9k6) begin
      pon_pend_nxt  = 1'b0;
      poff_pend_nxt = 1'b0;
      pb_pend_nxt   = 1'b0;
    end
    if (pon_edge) begin
      pon_pend_nxt = 1'b1;
    end
    if (s_poff && !poff_d_r) begin
      poff_pend_nxt = 1'b1;
    end
    if (s_pb && !pb_d_r) begin
      pb_pend_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_9k6_d_r <= 1'b0;
      tick_15_d_r  <= 1'b0;
      pon_d_r      <= 1'b0;
      poff_d_r     <= 1'b0;
      pb_d_r       <= 1'b0;
      pon_pend_r   <= 1'b0;
      poff_pend_r  <= 1'b0;
      pb_pend_r    <= 1'b0;
    end else begin
      tick_9k6_d_r <= tick_9k6;
      tick_15_d_r  <= tick_15;
      pon_d_r      <= s_pon;
      poff_d_r     <= s_poff;
      pb_d_r       <= s_pb;
      pon_pend_r   <= pon_pend_nxt;
      poff_pend_r  <= poff_pend_nxt;
      pb_pend_r    <= pb_pend_nxt;
    end
  end

  // Mode state machine
  format_pkg::mode_t mode_r;
  format_pkg::mode_t mode_nxt;

  always_comb begin
    mode_nxt = mode_r;
    if (stb_9k6) begin
      case (mode_r)
        format_pkg::MODE_OFF: begin
          if (pon_pend_r) begin
            mode_nxt = eot_record ? format_pkg::MODE_STANDBY : format_pkg::MODE_RECORD;
          end
        end
        format_pkg::MODE_RECORD: begin
          if (poff_pend_r) begin
            mode_nxt = format_pkg::MODE_OFF;
          end else if (eot_record) begin
            mode_nxt = format_pkg::MODE_STANDBY;
          end else if (pb_pend_r && pb_ok) begin
            mode_nxt = format_pkg::MODE_PLAYBACK;
          end
        end
        format_pkg::MODE_STANDBY: begin
          if (poff_pend_r) begin
            mode_nxt = format_pkg::MODE_OFF;
          end else if (pb_pend_r && pb_ok) begin
            mode_nxt = format_pkg::MODE_PLAYBACK;
          end
        end
        format_pkg::MODE_PLAYBACK: begin
          if (poff_pend_r) begin
            mode_nxt = format_pkg::MODE_OFF;
          end else if (pon_pend_r || eot_playback || !downlink_present) begin
            mode_nxt = format_pkg::MODE_RECORD;
          end
        end
        default: begin
          mode_nxt = format_pkg::MODE_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_r <= format_pkg::MODE_OFF;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Frame counters and playback delay
  logic                          active;
  logic                          in_pb;
  logic [format_pkg::BIT_W-1:0]  bit_r;
  logic [format_pkg::BIT_W-1:0]  bit_nxt;
  logic [format_pkg::WORD_W-1:0] word_r;
  logic [format_pkg::WORD_W-1:0] word_nxt;
  logic [format_pkg::CNT_W-1:0]  start_cnt_r;
  logic [format_pkg::CNT_W-1:0]  start_cnt_nxt;
  logic [format_pkg::CNT_W-1:0]  start_limit;
  assign active      = (mode_r != format_pkg::MODE_OFF);
  assign in_pb       = (mode_r == format_pkg::MODE_PLAYBACK);
  assign start_limit = format_pkg::CNT_W'(START_DELAY_CYCLES);

  always_comb begin
    bit_nxt       = bit_r;
    word_nxt      = word_r;
    start_cnt_nxt = start_cnt_r;
    if (!active || pon_edge) begin
      bit_nxt  = '0;
      word_nxt = '0;
    end else if (frame_timing_gate) begin
      bit_nxt = bit_r + 3'h1;
      if (bit_r == format_pkg::LAST_BIT) begin
        word_nxt = (word_r == format_pkg::LAST_WORD) ? '0 : word_r + 6'h01;
      end
    end
    if (!in_pb) begin
      start_cnt_nxt = '0;
    end else if (start_cnt_r != start_limit) begin
      start_cnt_nxt = start_cnt_r + 32'h00000001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bit_r       <= '0;
      word_r      <= '0;
      start_cnt_r <= '0;
    end else begin
      bit_r       <= bit_nxt;
      word_r      <= word_nxt;
      start_cnt_r <= start_cnt_nxt;
    end
  end

  // Track 3 bit selection
  logic       marker_bit_gate;
  logic       radiometer_window_gate;
  logic       track3_mux_gate_a;
  logic       track3_mux_gate_b;
  logic [5:0] tc_pos;
  logic       tc_bit;
  logic       t3_bit;
  assign marker_bit_gate        = (bit_r == format_pkg::MARKER_SLOT);
  assign radiometer_window_gate = (word_r >= format_pkg::RAD_FIRST_WORD) && (word_r <= format_pkg::RAD_LAST_WORD);
  assign track3_mux_gate_a      = radiometer_window_gate && s_rad;
  assign track3_mux_gate_b      = (word_r >= format_pkg::TLM_FIRST_WORD) && s_conv;
  assign tc_pos = 6'((word_r - format_pkg::TC_FIRST_WORD) * format_pkg::DATA_BITS + 6'(bit_r) - 6'h01);

  always_comb begin
    tc_bit = 1'b0;
    if (tc_pos < format_pkg::TC_BITS) begin
      tc_bit = tc_bus.word[tc_pos[4:0]];
    end
  end

  always_comb begin
    if (word_r <= format_pkg::FRAME_MARK_END) begin
      t3_bit = 1'b1;
    end else if (marker_bit_gate) begin
      t3_bit = 1'b0;
    end else if (word_r <= format_pkg::TC_LAST_WORD) begin
      t3_bit = tc_bit;
    end else begin
      t3_bit = track3_mux_gate_a || track3_mux_gate_b;
    end
  end

  // Registered outputs
  logic step_r;
  logic step_nxt;
  logic rst_fwd_r;
  logic conv_pwr_r;
  logic osc_pwr_r;
  logic osc_pwr_nxt;
  logic motor_n_r;
  logic start_n_r;
  logic start_n_nxt;
  logic proton_sync_flop;
  logic proton_nxt;
  logic track2_r;
  logic track2_nxt;
  logic track3_r;
  logic rad_clk_r;
  logic rad_word_r;
  logic rad_start_r;

  always_comb begin
    step_nxt    = (mode_r == format_pkg::MODE_RECORD) ? tick_15 : 1'b1;
    osc_pwr_nxt = in_pb;
    start_n_nxt = !(in_pb && (start_cnt_r == start_limit));
    proton_nxt  = (active && frame_timing_gate) ? s_proton : proton_sync_flop;
    track2_nxt  = (active && frame_timing_gate) ? !track2_r : track2_r;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      step_r           <= 1'b1;
      rst_fwd_r        <= 1'b0;
      conv_pwr_r       <= 1'b0;
      osc_pwr_r        <= 1'b0;
      motor_n_r        <= 1'b1;
      start_n_r        <= 1'b1;
      proton_sync_flop <= 1'b0;
      track2_r         <= 1'b0;
      track3_r         <= 1'b1;
      rad_clk_r        <= 1'b0;
      rad_word_r       <= 1'b0;
      rad_start_r      <= 1'b0;
    end else begin
      step_r           <= step_nxt;
      rst_fwd_r        <= s_pon;
      conv_pwr_r       <= active;
      osc_pwr_r        <= osc_pwr_nxt;
      motor_n_r        <= !in_pb;
      start_n_r        <= start_n_nxt;
      proton_sync_flop <= proton_nxt;
      track2_r         <= track2_nxt;
      track3_r         <= active ? t3_bit : 1'b1;
      rad_clk_r        <= active && tick_15;
      rad_word_r       <= active && marker_bit_gate;
      rad_start_r      <= active && (word_r == format_pkg::RAD_START_WORD);
    end
  end

  assign recorder_reset         = rst_fwd_r;
  assign converter_power_on     = conv_pwr_r;
  assign recorder_power_on      = conv_pwr_r;
  assign oscillator_power_on    = osc_pwr_r;
  assign playback_motor_n       = motor_n_r;
  assign playback_start_n       = start_n_r;
  assign recorder_step_clk      = step_r;
  assign track1_data            = proton_sync_flop;
  assign track2_data            = track2_r;
  assign track3_data            = track3_r;
  assign radiometer_shift_clk   = rad_clk_r;
  assign radiometer_word_strobe = rad_word_r;
  assign radiometer_start       = rad_start_r;

  sequence s_pb_entry;
    $rose(mode_r == format_pkg::MODE_PLAYBACK);
  endsequence

  property p_step_held;
    (mode_r != format_pkg::MODE_RECORD) |=> recorder_step_clk;
  endproperty
  a_step_held: assert property (p_step_held) else $error("step clock not held high");

  property p_record_entry;
    (stb_9k6 && pon_pend_r && !eot_record && mode_r == format_pkg::MODE_OFF) |=> mode_r == format_pkg::MODE_RECORD;
  endproperty
  a_record_entry: assert property (p_record_entry) else $error("power-on did not enter record");

  property p_pb_guard;
    s_pb_entry |-> $past(downlink_present) && !$past(eot_playback);
  endproperty
  a_pb_guard: assert property (p_pb_guard) else $error("playback entered without conditions");

  property p_pb_exit;
    (in_pb && stb_9k6 && !poff_pend_r && (eot_playback || !downlink_present)) |=>
      mode_r == format_pkg::MODE_RECORD;
  endproperty
  a_pb_exit: assert property (p_pb_exit) else $error("playback did not end");

  property p_off_hold;
    (!active && !(stb_9k6 && pon_pend_r)) |=> !active;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("left off mode without power-on");

  property p_motor;
    s_pb_entry |=> !playback_motor_n ##1 (!playback_motor_n || !in_pb);
  endproperty
  a_motor: assert property (p_motor) else $error("motor enable not low in playback");

  property p_start_delay;
    $fell(playback_start_n) |-> !playback_motor_n && ($past(start_cnt_r) == start_limit);
  endproperty
  a_start_delay: assert property (p_start_delay) else $error("playback start timing wrong");

  property p_marker;
    (active && marker_bit_gate && word_r > format_pkg::FRAME_MARK_END) |=> !track3_data;
  endproperty
  a_marker: assert property (p_marker) else $error("word marker not zero");

  property p_frame_mark;
    (active && word_r <= format_pkg::FRAME_MARK_END) |=> track3_data;
  endproperty
  a_frame_mark: assert property (p_frame_mark) else $error("frame marker not ones");

  property p_rad_start;
    (active && word_r == format_pkg::RAD_START_WORD) |=> radiometer_start;
  endproperty
  a_rad_start: assert property (p_rad_start) else $error("radiometer start missing");

  property p_track2;
    (active && frame_timing_gate) |=> (track2_data != $past(track2_data));
  endproperty
  a_track2: assert property (p_track2) else $error("track 2 did not toggle");
endmodule

/* File: timing_unit_model.sv */
// Timing unit model: unit A active, unit B standby with grounded pins.
// Assumes rates scaled down so that a whole frame fits a short run.
`timescale 1ns/1ns
module timing_unit_model (
  input  wire logic  clk,
  input  wire logic  reset,
  output logic       tick_9k6,
  output logic       tick_15hz,
  output logic [2:0] tc_pins,
  output logic [4:0] unit_b_pins,
  output logic [1:0] standby_n
);
  int cnt;
  always @(posedge clk or posedge reset)
    if (reset) cnt <= 0;
    else cnt <= cnt + 1;
  assign tick_9k6  = (cnt % 16) < 8;
  assign tick_15hz = (cnt % 40) < 20;
  assign tc_pins = {cnt[9:5] == 5'h00, cnt[6], cnt[3]};
  assign unit_b_pins = 5'h00;
  assign standby_n   = 2'h1;
endmodule

/* File: tape_frame_formatter_mode_control_tb.sv */
// Self-checking bench for the mode sequencer and frame builder.
// Assumes the timing unit model drives scaled rates; bench drives commands.
`timescale 1ns/1ns
module tape_frame_formatter_mode_control_tb;
  localparam int DLY = 40;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [2:0] cmd = 3'h0;
  logic [2:0] lvl = 3'h7;
  logic [2:0] dat = 3'h0;
  wire        t9, t15;
  wire [2:0]  tc;
  wire [4:0]  ub;
  wire [1:0]  sb_n;
  wire [12:0] st;
  int         err_total = 0;
  int         comparisons = 0;

  always #20 clk = ~clk;

  timing_unit_model tu (.clk(clk), .reset(reset), .tick_9k6(t9), .tick_15hz(t15), .tc_pins(tc),
    .unit_b_pins(ub), .standby_n(sb_n));
  tape_frame_formatter_mode_control #(.START_DELAY_CYCLES(DLY)) DUT (.clk(clk), .reset(reset),
    .tick_9k6_a(t9), .tick_9k6_b(ub[0]), .tick_15hz_a(t15), .tick_15hz_b(ub[1]), .tc_clk_a(tc[0]),
    .tc_clk_b(ub[2]), .tc_data_a(tc[1]), .tc_data_b(ub[3]), .tc_rest_a(tc[2]), .tc_rest_b(ub[4]),
    .unit_a_standby_n(sb_n[0]), .unit_b_standby_n(sb_n[1]), .power_on_cmd(cmd[0]),
    .power_off_cmd(cmd[1]), .playback_cmd(cmd[2]), .eot_record_n(lvl[0]), .eot_playback_n(lvl[1]),
    .downlink_ground_n(lvl[2]), .proton_monitor_data(dat[0]), .plate_radiometer_data(dat[1]),
    .converter_serial_out(dat[2]), .recorder_step_clk(st[1]), .recorder_reset(st[9]),
    .converter_power_on(st[2]), .recorder_power_on(st[10]), .oscillator_power_on(st[3]),
    .playback_motor_n(st[4]), .playback_start_n(st[5]), .track1_data(st[0]), .track2_data(st[8]),
    .track3_data(st[11]), .radiometer_shift_clk(st[12]), .radiometer_word_strobe(st[7]),
    .radiometer_start(st[6]));

  task automatic end_sim;
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      err_total++;
      $display("Error %0t: length %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic wait_for(input int i, input logic v, input int lim);
    for (int k = 0; k < lim && st[i] !== v; k++) @(negedge clk);
    chk(st[i], v);
  endtask
  task automatic pulse(input int i);
    cmd[i] = 1'b1;
    repeat (20) @(negedge clk);
    cmd[i] = 1'b0;
    repeat (40) @(negedge clk);
  endtask
  task automatic meas(input int i, input int exp);
    int n;
    n = 0;
    wait_for(i, 1'b0, 400);
    wait_for(i, 1'b1, 20000);
    while (st[i] === 1'b1 && n < 1000) begin
      n++;
      @(negedge clk);
    end
    chkn(n, exp);
  endtask

  task automatic t_record;
    cmd[0] = 1'b1;
    wait_for(9, 1'b1, 20);
    repeat (20) @(negedge clk);
    cmd[0] = 1'b0;
    wait_for(2, 1'b1, 40);
    wait_for(1, 1'b0, 60);
    wait_for(1, 1'b1, 60);
  endtask
  task automatic t_frame;
    meas(6, 320);
    meas(7, 40);
    meas(8, 40);
    meas(12, 20);
    dat = 3'h7;
    repeat (100) @(negedge clk);
    chk(st[0], 1'b1);
    dat = 3'h0;
    repeat (100) @(negedge clk);
    chk(st[0], 1'b0);
  endtask
  task automatic t_track3;
    dat = 3'h4;
    wait_for(6, 1'b0, 400);
    wait_for(6, 1'b1, 20000);
    chk(st[11], 1'b0);
    repeat (60) @(negedge clk);
    chk(st[11], 1'b1);
    repeat (120) @(negedge clk);
    chk(st[11], 1'b0);
    wait_for(6, 1'b0, 400);
    repeat (60) @(negedge clk);
    chk(st[11], 1'b0);
    dat = 3'h2;
    repeat (10) @(negedge clk);
    chk(st[11], 1'b1);
    dat = 3'h4;
    repeat (4790) @(negedge clk);
    chk(st[11], 1'b1);
    dat = 3'h2;
    repeat (10) @(negedge clk);
    chk(st[11], 1'b0);
    dat = 3'h0;
  endtask
  task automatic t_refuse;
    pulse(2);
    chk(st[4], 1'b1);
    lvl = 3'h1;
    pulse(2);
    chk(st[4], 1'b1);
    lvl = 3'h3;
  endtask
  task automatic t_play(input int way);
    lvl[2] = 1'b0;
    repeat (20) @(negedge clk);
    cmd[2] = 1'b1;
    wait_for(4, 1'b0, 40);
    repeat (DLY - 1) @(negedge clk);
    chk(st[5], 1'b1);
    chk(st[3], 1'b1);
    @(negedge clk);
    chk(st[5], 1'b0);
    cmd[2] = 1'b0;
    repeat (45) @(negedge clk);
    chk(st[1], 1'b1);
    case (way)
      0: lvl[2] = 1'b1;
      1: lvl[1] = 1'b0;
      default: cmd[0] = 1'b1;
    endcase
    wait_for(4, 1'b1, 60);
    chk(st[5], 1'b1);
    chk(st[3], 1'b0);
    cmd[0] = 1'b0;
    lvl = 3'h7;
    wait_for(1, 1'b0, 80);
  endtask
  task automatic t_standby;
    lvl[0] = 1'b0;
    repeat (60) @(negedge clk);
    for (int k = 0; k < 3; k++) begin
      repeat (15) @(negedge clk);
      chk(st[1], 1'b1);
    end
    meas(8, 40);
    pulse(0);
    repeat (45) @(negedge clk);
    chk(st[1], 1'b1);
    lvl = 3'h2;
    pulse(2);
    chk(st[4], 1'b0);
    lvl = 3'h7;
    wait_for(4, 1'b1, 60);
  endtask
  task automatic t_off;
    pulse(1);
    chk(st[2], 1'b0);
    chk(st[10], 1'b0);
    lvl[2] = 1'b0;
    pulse(2);
    chk(st[4], 1'b1);
    lvl[2] = 1'b1;
    pulse(0);
    chk(st[2], 1'b1);
  endtask

  initial begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    chk(st[2], 1'b0);
    chk(st[4], 1'b1);
    chk(st[5], 1'b1);
    chk(st[1], 1'b1);
    t_record();
    t_frame();
    t_track3();
    t_refuse();
    for (int w = 0; w < 3; w++) t_play(w);
    t_standby();
    t_off();
    end_sim();
  end
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    end_sim();
  end
endmodule
